// ==== src/ipr_pkg.sv ====
// Behaviour
// - Control bit page_transfer_enable allows multi-byte page transfers; resets to one.
// - Control bit hung_bus_timer_enable arms the hung-bus recovery timer; resets to one.
// - Control bits one and zero always read zero and ignore written values.
// - With page_transfer_enable set, each master acknowledge of a read byte advances the pointer and sends next register; cleared, the same register repeats.
// - A Stop ends the transaction and returns the register pointer to zero.
// - After the command byte only its low three bits load the register pointer.
package ipr_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_FREQ_MHZ  = 200;
  localparam int unsigned STUCK_TIME_US = 1000;
  localparam int unsigned STUCK_CYCLES  = STUCK_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned STUCK_CNT_W   = 24;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [2:0] REG_SENSE_HI = 3'h0;
  localparam logic [2:0] REG_SENSE_LO = 3'h1;
  localparam logic [2:0] REG_VIN_HI   = 3'h2;
  localparam logic [2:0] REG_VIN_LO   = 3'h3;
  localparam logic [2:0] REG_ADIN_HI  = 3'h4;
  localparam logic [2:0] REG_ADIN_LO  = 3'h5;
  localparam logic [2:0] REG_CTRL     = 3'h6;
  localparam logic [2:0] REG_RSVD     = 3'h7;
  localparam logic [2:0] PTR_RESET    = 3'h0;

  // ****************************************
  // Control register layout
  // ****************************************
  localparam int unsigned CTRL_PAGE_BIT  = 3;
  localparam int unsigned CTRL_TIMER_BIT = 2;
  localparam int unsigned CTRL_WR_LSB    = 2;
  localparam logic [7:0]  CTRL_RESET     = 8'h0C;
  localparam logic [1:0]  CTRL_RSVD_VAL  = 2'h0;

  typedef struct packed {
    logic       snapshot_enable;
    logic [1:0] snapshot_channel;
    logic       test_mode_enable;
    logic       page_transfer_enable;
    logic       hung_bus_timer_enable;
    logic [1:0] control_reserved_low;
  } ipr_ctrl_type;

  typedef struct packed {
    logic [7:0] sense_hi;
    logic [7:0] sense_lo;
    logic [7:0] vin_hi;
    logic [7:0] vin_lo;
    logic [7:0] adin_hi;
    logic [7:0] adin_lo;
  } ipr_adc_type;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_RACK,
    ST_RLOAD
  } ipr_state_type;

endpackage

// ==== src/ipr_page_read_control.sv ====
`timescale 1ns/1ps
module ipr_page_read_control
  import ipr_pkg::*;
#(
  parameter int unsigned STUCK_LIMIT = STUCK_CYCLES
) (
  input  wire logic         core_clk_in,    // Core clock, 200 MHz
  input  wire logic         rst_n_in,       // Synchronous reset, active low
  input  wire logic         clk_en_in,      // Freezes all state while low
  input  wire logic [6:0]   slave_addr_in,  // Own 7-bit bus address
  input  wire logic         scl_in,         // Bus clock level
  input  wire logic         sda_in,         // Bus data level
  output logic              sda_out,        // Data drive value, always low
  output logic              sda_oe_out,     // High while pulling data low
  input  wire ipr_adc_type  adc_data_in,    // Conversion result bytes
  output ipr_ctrl_type      ctrl_out,       // Control register contents
  output logic [2:0]        reg_ptr_out,    // Register pointer
  output logic              bus_active_out  // Transaction in progress
);

  // ****************************************
  // Bus edge and condition detection
  // ****************************************
  logic          scl_q;
  logic          sda_q;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_cond;
  logic          stop_cond;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (clk_en_in) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;

  // ****************************************
  // State and shared signals
  // ****************************************
  ipr_state_type state;
  ipr_state_type ack_from;
  ipr_ctrl_type  ctrl;
  logic [2:0]    ptr;
  logic [2:0]    bit_cnt;
  logic [7:0]    rx_sh;
  logic [7:0]    tx_sh;
  logic [7:0]    rx_byte;
  logic          rd_dir;
  logic          ack_drv;
  logic          rx_state;
  logic          byte_full;
  logic          addr_match;
  logic          master_ack;
  logic          timeout;
  logic [STUCK_CNT_W-1:0] stuck_cnt;

  assign rx_byte    = {rx_sh[6:0], sda_in};
  assign rx_state   = (state == ST_ADDR) || (state == ST_CMD) || (state == ST_WDATA);
  assign byte_full  = rx_state && scl_rise && (bit_cnt == 3'h7);
  assign addr_match = rx_byte[7:1] == slave_addr_in;
  assign master_ack = (state == ST_RACK) && scl_rise && !sda_in;

  function automatic logic [7:0] read_reg(input logic [2:0] idx, input ipr_adc_type adc,
                                          input ipr_ctrl_type c);
    logic [7:0] val;
    val = 8'h00;
    case (idx)
      REG_SENSE_HI: val = adc.sense_hi;
      REG_SENSE_LO: val = adc.sense_lo;
      REG_VIN_HI:   val = adc.vin_hi;
      REG_VIN_LO:   val = adc.vin_lo;
      REG_ADIN_HI:  val = adc.adin_hi;
      REG_ADIN_LO:  val = adc.adin_lo;
      REG_CTRL:     val = {c[7:CTRL_WR_LSB], CTRL_RSVD_VAL};
      default:      val = 8'h00;
    endcase
    return val;
  endfunction

  // ****************************************
  // Hung-bus timer
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      stuck_cnt <= '0;
    end else if (clk_en_in) begin
      if (state == ST_IDLE || scl_in || timeout) begin
        stuck_cnt <= '0;
      end else begin
        stuck_cnt <= stuck_cnt + 1'b1;
      end
    end
  end

  assign timeout = ctrl.hung_bus_timer_enable && (stuck_cnt >= STUCK_LIMIT[STUCK_CNT_W-1:0]);

  // ****************************************
  // Transfer state machine
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state    <= ST_IDLE;
      ack_from <= ST_IDLE;
      bit_cnt  <= 3'h0;
      rx_sh    <= 8'h00;
      rd_dir   <= 1'b0;
      ack_drv  <= 1'b0;
    end else if (clk_en_in) begin
      if (timeout || stop_cond) begin
        state   <= ST_IDLE;
        ack_drv <= 1'b0;
      end else if (start_cond) begin
        state   <= ST_ADDR;
        bit_cnt <= 3'h0;
        ack_drv <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_CMD, ST_WDATA: begin
            if (scl_rise) begin
              rx_sh   <= rx_byte;
              bit_cnt <= bit_cnt + 3'h1;
              if (byte_full) begin
                ack_from <= state;
                if (state == ST_ADDR) begin
                  rd_dir <= rx_byte[0];
                  state  <= addr_match ? ST_ACK : ST_IDLE;
                end else begin
                  state <= ST_ACK;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (!ack_drv) begin
                ack_drv <= 1'b1;
              end else begin
                ack_drv <= 1'b0;
                bit_cnt <= 3'h0;
                if (ack_from == ST_ADDR) begin
                  state <= rd_dir ? ST_RDATA : ST_CMD;
                end else begin
                  state <= ST_WDATA;
                end
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                state <= ST_RACK;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              state <= sda_in ? ST_IDLE : ST_RLOAD;
            end
          end
          ST_RLOAD: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              state   <= ST_RDATA;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Register pointer
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ptr <= PTR_RESET;
    end else if (clk_en_in) begin
      if (stop_cond || timeout) begin
        ptr <= PTR_RESET;
      end else if (byte_full && state == ST_CMD) begin
        ptr <= rx_byte[2:0];
      end else if (master_ack || (byte_full && state == ST_WDATA)) begin
        if (ctrl.page_transfer_enable) begin
          ptr <= ptr + 3'h1;
        end
      end
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctrl <= ipr_ctrl_type'(CTRL_RESET);
    end else if (clk_en_in) begin
      if (byte_full && state == ST_WDATA && ptr == REG_CTRL) begin
        ctrl <= ipr_ctrl_type'({rx_byte[7:CTRL_WR_LSB], CTRL_RSVD_VAL});
      end
    end
  end

  // ****************************************
  // Transmit shifter
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tx_sh <= 8'hFF;
    end else if (clk_en_in) begin
      if (state == ST_ACK && ack_drv && scl_fall && ack_from == ST_ADDR && rd_dir) begin
        tx_sh <= read_reg(ptr, adc_data_in, ctrl);
      end else if (state == ST_RLOAD && scl_fall) begin
        tx_sh <= read_reg(ptr, adc_data_in, ctrl);
      end else if (state == ST_RDATA && scl_fall) begin
        tx_sh <= {tx_sh[6:0], 1'b1};
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sda_out        = 1'b0;
  assign sda_oe_out     = (state == ST_ACK && ack_drv) || (state == ST_RDATA && !tx_sh[7]);
  assign ctrl_out       = ctrl;
  assign reg_ptr_out    = ptr;
  assign bus_active_out = state != ST_IDLE;

endmodule // ipr_page_read_control

// ==== dv/ipr_page_read_control_checker.sv ====
`timescale 1ns/1ps
module ipr_checker
  import ipr_pkg::*;
#(
  parameter int unsigned STUCK_LIMIT = STUCK_CYCLES
) (
  input wire logic         core_clk_in,
  input wire logic         rst_n_in,
  input wire logic         clk_en_in,
  input wire logic         scl_in,
  input wire logic         sda_in,
  input wire logic         sda_oe_out,
  input wire ipr_ctrl_type ctrl_out,
  input wire logic [2:0]   reg_ptr_out,
  input wire logic         bus_active_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ****
  // Clock-low run length
  // ****
  logic [23:0] low_cnt;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !bus_active_out || scl_in || !ctrl_out.hung_bus_timer_enable) begin
      low_cnt <= 24'h0;
    end else if (clk_en_in) begin
      low_cnt <= low_cnt + 24'h1;
    end
  end
  a_freeze_hold: assert property (rst_n_in && !clk_en_in |=> $stable(reg_ptr_out) && $stable(ctrl_out) && $stable(bus_active_out))
    else $error("state changed while clock enable low");
  a_ctrl_reset_val: assert property (disable iff (1'b0) !rst_n_in |=> ctrl_out == 8'h0C)
    else $error("control reset value wrong");
  a_idle_on_reset: assert property (disable iff (1'b0)
    !rst_n_in |=> reg_ptr_out == 3'h0 && !bus_active_out && !sda_oe_out)
    else $error("pointer or bus state not cleared by reset");
  a_rsvd_low_zero: assert property (ctrl_out.control_reserved_low == 2'h0)
    else $error("reserved control bits not zero");
  a_stop_ptr_zero: assert property (scl_in && $past(scl_in) && sda_in && !$past(sda_in)
    |-> ##[1:2] reg_ptr_out == 3'h0)
    else $error("pointer not zero after stop");
  a_start_busy: assert property (scl_in && $past(scl_in) && !sda_in && $past(sda_in)
    |-> ##[1:2] bus_active_out)
    else $error("start not taken");
  a_oe_in_txn: assert property (sda_oe_out |-> bus_active_out)
    else $error("data driven outside transaction");
  a_oe_hold_high: assert property ($past(scl_in, 2) && $past(scl_in) && scl_in |-> $stable(sda_oe_out))
    else $error("data drive changed while clock high");
  a_ctrl_by_bus: assert property ($changed(ctrl_out) |-> $past(bus_active_out))
    else $error("control changed outside transaction");
  a_stuck_bound: assert property (int'(low_cnt) <= STUCK_LIMIT + 2)
    else $error("hung bus not released in time");
  c_stop: cover property (scl_in && $past(scl_in) && sda_in && !$past(sda_in));
  c_drive: cover property ($rose(sda_oe_out));
  c_long_low: cover property (low_cnt == 24'h20);
  c_freeze: cover property (!clk_en_in && bus_active_out);
endmodule // ipr_checker

bind ipr_page_read_control ipr_checker #(.STUCK_LIMIT(STUCK_LIMIT)) u_chk (
  .core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in),
  .clk_en_in(clk_en_in),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_oe_out(sda_oe_out),
  .ctrl_out(ctrl_out),
  .reg_ptr_out(reg_ptr_out),
  .bus_active_out(bus_active_out)
);

// ==== dv/ipr_bus_master.sv ====
`timescale 1ns/1ps
module ipr_bus_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic start();
    sda_out = 1'b1;
    w(2);
    scl_out = 1'b1;
    w(3);
    sda_out = 1'b0;
    w(3);
    scl_out = 1'b0;
    w(2);
  endtask
  task automatic stop();
    sda_out = 1'b0;
    w(2);
    scl_out = 1'b1;
    w(3);
    sda_out = 1'b1;
    w(3);
  endtask
  task automatic bit_x(input logic d, output logic q);
    sda_out = d;
    w(2);
    scl_out = 1'b1;
    w(2);
    q = sda_in;
    w(2);
    scl_out = 1'b0;
    w(2);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bit_x(b[i], q);
    bit_x(1'b1, q);
    ack = !q;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, q);
      d[i] = q;
    end
    bit_x(!ack, q);
  endtask
endmodule // ipr_bus_master

// ==== dv/ipr_page_read_control_test.sv ====
`timescale 1ns/1ps
module ipr_page_read_control_test;
  import ipr_pkg::*;
  localparam logic [6:0] ADDR = 7'h2A;
  logic         clk;
  logic         rst_n;
  logic         clk_en;
  logic         scl;
  logic         msda;
  logic         sda_oe;
  logic         act;
  logic         a;
  logic [2:0]   ptr;
  logic [7:0]   exp_ctrl;
  ipr_ctrl_type ctrl;
  ipr_adc_type  adc;
  wire          sda = msda & ~sda_oe;
  int           miscompares;
  int           samples_checked;
  logic [11:0]  rows [3] = '{12'hF89, 12'h053, 12'h6E1};
  ipr_page_read_control #(.STUCK_LIMIT(64)) DUT (
    .core_clk_in(clk),
    .rst_n_in(rst_n),
    .clk_en_in(clk_en),
    .slave_addr_in(ADDR),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(),
    .sda_oe_out(sda_oe),
    .adc_data_in(adc),
    .ctrl_out(ctrl),
    .reg_ptr_out(ptr),
    .bus_active_out(act)
  );
  ipr_bus_master m (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(msda));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [7:0] reg_val(input logic [2:0] r);
    logic [47:0] v;
    v = adc;
    return (r < 3'h6) ? v[47 - 8 * r -: 8] : ((r == 3'h6) ? exp_ctrl : 8'h00);
  endfunction
  task automatic rd(input logic [7:0] cmd, input int n, input logic use_cmd);
    logic [7:0] d;
    logic [2:0] p;
    p = use_cmd ? cmd[2:0] : 3'h0;
    m.start();
    if (use_cmd) begin
      m.wbyte({ADDR, 1'b0}, a);
      m.wbyte(cmd, a);
      m.start();
    end
    m.wbyte({ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i < n - 1, d);
      chk(d, reg_val(p));
      if (exp_ctrl[3]) p = p + 3'h1;
    end
    m.stop();
    chk(ptr, 3'h0);
  endtask
  task automatic wr(input logic [7:0] v);
    m.start();
    m.wbyte({ADDR, 1'b0}, a);
    m.wbyte(8'h06, a);
    m.wbyte(v, a);
    m.stop();
    exp_ctrl = {v[7:2], 2'h0};
    chk(ctrl, exp_ctrl);
  endtask
  task automatic hang(input logic stay, input logic frz);
    m.start();
    m.wbyte({ADDR, 1'b0}, a);
    m.wbyte(8'h03, a);
    clk_en = !frz;
    m.w(80);
    chk(act, stay || frz);
    chk(ptr, (stay || frz) ? 3'h3 : 3'h0);
    clk_en = 1'b1;
    m.w(80);
    chk(act, stay);
    m.stop();
    chk(act, 1'b0);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    exp_ctrl = 8'h0C;
    adc = 48'h112233445566;
    m.w(5);
    rst_n = 1'b1;
    chk(ctrl, 8'h0C);
    chk(ptr, 3'h0);
    m.w(2);
    foreach (rows[k]) rd(rows[k][11:4], rows[k][3:0], 1'b1);
    wr(8'hF3);
    rd(8'h02, 3, 1'b1);
    rd(8'h00, 2, 1'b0);
    wr(8'h0F);
    rd(8'h00, 2, 1'b0);
    m.start();
    m.wbyte({~ADDR, 1'b0}, a);
    chk(a, 1'b0);
    m.stop();
    hang(1'b0, 1'b0);
    hang(1'b0, 1'b1);
    wr(8'h08);
    hang(1'b1, 1'b0);
    m.start();
    m.wbyte({ADDR, 1'b0}, a);
    m.wbyte(8'h05, a);
    rst_n = 1'b0;
    m.w(2);
    rst_n = 1'b1;
    exp_ctrl = 8'h0C;
    chk(ctrl, 8'h0C);
    chk(ptr, 3'h0);
    chk(act, 1'b0);
    m.w(2);
    rd(8'h06, 2, 1'b1);
    tally_and_finish();
  end
endmodule // ipr_page_read_control_test
